// *** hdl/rsus_defines.svh ***
// Register indices, field positions and reset values of the signaling/slip block
`ifndef RSUS_DEFINES_SVH
`define RSUS_DEFINES_SVH

// Register indices; byte address is four times the index
`define RSUS_IDX_SIG_CFG     9'h0D7
`define RSUS_IDX_FRM_OFS     9'h0D8
`define RSUS_IDX_SLIP_BUFFER_STATUS       9'h0D9
`define RSUS_IDX_OUTBUF_HI   4'hD
`define RSUS_IDX_QUEUE_EN    9'h1C0
`define RSUS_IDX_REINS_EN    9'h1C1
`define RSUS_IDX_LINE_CFG    9'h1C2

// Signaling configuration fields
`define RSUS_CFG_TRANSPARENT 0
`define RSUS_CFG_HOLD        1
`define RSUS_CFG_RELEASE     2
`define RSUS_CFG_DEBOUNCE    3

// Line configuration fields
`define RSUS_LCFG_STD        0
`define RSUS_LCFG_TX_LO      1
`define RSUS_LCFG_RX_LO      3

// Slip status nibble positions
`define RSUS_ST_DIR          3
`define RSUS_ST_CTL          2
`define RSUS_ST_UNC          1
`define RSUS_ST_DLY          0

// Reset values
`define RSUS_RST_SIG_CFG     4'h0
`define RSUS_RST_FRM_OFS     5'h00
`define RSUS_RST_SLIP_BUFFER_STATUS       8'h00
`define RSUS_RST_MASK32      32'h00000000

// Frame numbering and delay thresholds
`define RSUS_T1_FRAMES       5'd24
`define RSUS_E1_FRAMES       5'd16
`define RSUS_T1_DLY_BITS     9'd192
`define RSUS_E1_DLY_BITS     9'd256
`define RSUS_T1_SIG_F1       5'd6
`define RSUS_T1_SIG_F2       5'd12
`define RSUS_T1_SIG_F3       5'd18
`define RSUS_T1_SIG_F4       5'd24

`endif

// *** hdl/rsus_pkg.sv ***
// Types shared by the signaling update and slip status block
package rsus_pkg;

  typedef enum logic [1:0] {
    RSUS_BUF_NORMAL  = 2'b00,
    RSUS_BUF_SHORT   = 2'b01,
    RSUS_BUF_ELASTIC = 2'b10,
    RSUS_BUF_BYPASS  = 2'b11
  } rsus_buf_mode_t;

  typedef enum logic [0:0] {
    RSUS_BUS_IDLE = 1'b0,
    RSUS_BUS_ACK  = 1'b1
  } rsus_bus_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [10:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rsus_avs_req_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
    logic [3:0] abcd;
  } rsus_sig_in_t;

  typedef struct packed {
    logic       push;
    logic [4:0] chan;
    logic [3:0] abcd;
  } rsus_queue_t;

  typedef struct packed {
    logic       controlled;
    logic       uncontrolled;
    logic       repeated;
    logic [8:0] separation;
  } rsus_slip_evt_t;

  typedef struct packed {
    rsus_bus_state_t  bus;
    logic [31:0]      rdata;
    logic [3:0]       sig_cfg;
    logic [4:0]       frm_ofs;
    logic             std_t1;
    rsus_buf_mode_t   tx_mode;
    rsus_buf_mode_t   rx_mode;
    logic [31:0]      queue_en;
    logic [31:0]      reins_en;
    logic [31:0][3:0] in_buf;
    logic [31:0][3:0] out_buf;
    logic [7:0]       slip_buffer_status;
    logic [2:0]       tx_pend;
    logic [2:0]       rx_pend;
    logic [4:0]       mf_pos;
    logic             freeze_pin;
    rsus_queue_t      queue;
    logic             mf_sync;
    logic             reins_frame;
    logic             tx_int;
    logic             rx_int;
    logic             tx_realign;
    logic             rx_realign;
  } rsus_state_t;

endpackage

// *** hdl/rsus_top.sv ***
// Receive signaling update, multiframe sync offset and slip status for one framer
`timescale 1ns/1ps
`default_nettype none
`include "rsus_defines.svh"

module rsus_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_srst,
  input  wire rsus_pkg::rsus_avs_req_t i_avs,
  output logic                      o_avs_waitrequest,
  output logic [31:0]               o_avs_readdata,
  input  wire rsus_pkg::rsus_sig_in_t  i_sig,
  input  wire logic                 i_mf_end,
  input  wire logic                 i_freeze_cond,
  input  wire logic                 i_rx_frame_start,
  input  wire logic [4:0]           i_rx_frame_num,
  input  wire logic [4:0]           i_rx_mf_align_frame,
  input  wire logic                 i_rx_slip_delay_frame,
  input  wire logic                 i_tx_frame_start,
  input  wire rsus_pkg::rsus_slip_evt_t i_tx_slip,
  input  wire rsus_pkg::rsus_slip_evt_t i_rx_slip,
  output logic                      o_signaling_freeze_pin,
  output rsus_pkg::rsus_queue_t     o_queue,
  output logic                      o_rx_multiframe_sync,
  output logic                      o_reinsert_frame,
  output logic [31:0]               o_reinsert_enable,
  output logic                      o_tx_slip_int,
  output logic                      o_rx_slip_int,
  output logic                      o_tx_frame_realign,
  output logic                      o_rx_frame_realign
);
  import rsus_pkg::*;

  rsus_state_t st_reg;
  rsus_state_t st_next;

  // Byte-lane merge of a 32-bit register write
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Which slip kinds a buffer mode may report, as {controlled, uncontrolled}
  function automatic logic [1:0] slip_mask(input rsus_buf_mode_t m,
                                           input logic ctl,
                                           input logic unc);
    logic [1:0] r;
    case (m)
      RSUS_BUF_NORMAL:  r = {ctl, unc};
      // Short mode reverts on slip, so one kind only; uncontrolled wins
      RSUS_BUF_SHORT:   r = unc ? 2'b01 : {ctl, 1'b0};
      RSUS_BUF_ELASTIC: r = {1'b0, unc};
      default:          r = 2'b00;
    endcase
    return r;
  endfunction

  // Frame selected by the offset code
  function automatic logic [4:0] ofs_frame(input logic [4:0] ofs, input logic t1);
    logic [4:0] r;
    r = t1 ? 5'(ofs + 5'd1) : {1'b0, ofs[3:0]};
    return r;
  endfunction

  // Received alignment frame pushed on by the slip buffer delay, wrapped
  function automatic logic [4:0] wrap_frame(input logic [4:0] f,
                                            input logic       dly,
                                            input logic       t1);
    logic [5:0] s;
    logic [4:0] r;
    s = {1'b0, f} + {5'h00, dly};
    if (t1)
    begin
      r = (s > {1'b0, `RSUS_T1_FRAMES}) ? 5'(s - {1'b0, `RSUS_T1_FRAMES}) : s[4:0];
    end
    else
    begin
      r = (s >= {1'b0, `RSUS_E1_FRAMES}) ? 5'(s - {1'b0, `RSUS_E1_FRAMES}) : s[4:0];
    end
    return r;
  endfunction

  // Delay-over-frame test on the read/write pointer separation
  function automatic logic over_frame(input logic [8:0] sep, input logic t1);
    logic r;
    r = t1 ? (sep > `RSUS_T1_DLY_BITS) : (sep > `RSUS_E1_DLY_BITS);
    return r;
  endfunction

  logic        req;
  logic        take;
  logic [8:0]  idx;
  logic        hold;
  logic        release_bit;
  logic        freeze_eff;
  logic        debounce;
  logic        chan_queued;
  logic [3:0]  cur_in;
  logic [3:0]  cur_out;
  logic [3:0]  new_out;
  logic [1:0]  tx_ev;
  logic [1:0]  rx_ev;
  logic        tx_dir;
  logic        rx_dir;
  logic [3:0]  tx_nib;
  logic [3:0]  rx_nib;
  logic [4:0]  sync_frame;
  logic        sync_hit;
  logic [4:0]  pos_now;

  always_comb
  begin
    st_next = st_reg;
    req     = i_avs.read | i_avs.write;
    idx     = i_avs.address[10:2];
    take    = req && (st_reg.bus == RSUS_BUS_IDLE);

    // Register bus: one wait cycle, then answer for a single cycle
    st_next.bus = take ? RSUS_BUS_ACK : RSUS_BUS_IDLE;
    if (take && i_avs.read)
    begin
      case (idx)
        `RSUS_IDX_SIG_CFG:  st_next.rdata = {28'h0000000, st_reg.sig_cfg};
        `RSUS_IDX_FRM_OFS:  st_next.rdata = {27'h0000000, st_reg.frm_ofs};
        `RSUS_IDX_SLIP_BUFFER_STATUS:    st_next.rdata = {24'h000000, st_reg.slip_buffer_status};
        `RSUS_IDX_QUEUE_EN: st_next.rdata = st_reg.queue_en;
        `RSUS_IDX_REINS_EN: st_next.rdata = st_reg.reins_en;
        `RSUS_IDX_LINE_CFG: st_next.rdata = {27'h0000000, st_reg.rx_mode,
                                             st_reg.tx_mode, st_reg.std_t1};
        default:
        begin
          if (idx[8:5] == `RSUS_IDX_OUTBUF_HI)
          begin
            st_next.rdata = {28'h0000000, st_reg.out_buf[idx[4:0]]};
          end
          else
          begin
            st_next.rdata = 32'h00000000;
          end
        end
      endcase
    end
    if (take && i_avs.write)
    begin
      case (idx)
        `RSUS_IDX_SIG_CFG:
        begin
          if (i_avs.byteenable[0])
          begin
            st_next.sig_cfg = i_avs.writedata[3:0];
          end
        end
        `RSUS_IDX_FRM_OFS:
        begin
          if (i_avs.byteenable[0])
          begin
            st_next.frm_ofs = i_avs.writedata[4:0];
          end
        end
        `RSUS_IDX_QUEUE_EN:
        begin
          st_next.queue_en = be_merge(st_reg.queue_en, i_avs.writedata,
                                      i_avs.byteenable);
        end
        `RSUS_IDX_REINS_EN:
        begin
          st_next.reins_en = be_merge(st_reg.reins_en, i_avs.writedata,
                                      i_avs.byteenable);
        end
        `RSUS_IDX_LINE_CFG:
        begin
          if (i_avs.byteenable[0])
          begin
            st_next.std_t1  = i_avs.writedata[`RSUS_LCFG_STD];
            st_next.tx_mode = rsus_buf_mode_t'(i_avs.writedata[`RSUS_LCFG_TX_LO +: 2]);
            st_next.rx_mode = rsus_buf_mode_t'(i_avs.writedata[`RSUS_LCFG_RX_LO +: 2]);
          end
        end
        default:
        begin
          st_next.rdata = st_reg.rdata;
        end
      endcase
    end

    // Freeze: release beats hold, and hold beats the freeze condition
    hold        = st_reg.sig_cfg[`RSUS_CFG_HOLD];
    release_bit = st_reg.sig_cfg[`RSUS_CFG_RELEASE];
    debounce    = st_reg.sig_cfg[`RSUS_CFG_DEBOUNCE];
    if (release_bit)
    begin
      freeze_eff = 1'b0;
    end
    else if (hold)
    begin
      freeze_eff = 1'b1;
    end
    else
    begin
      freeze_eff = i_freeze_cond;
    end
    st_next.freeze_pin = freeze_eff;

    // Signaling update after the D bit of a channel
    chan_queued        = st_reg.queue_en[i_sig.chan];
    cur_in             = st_reg.in_buf[i_sig.chan];
    cur_out            = st_reg.out_buf[i_sig.chan];
    new_out            = i_sig.abcd;
    st_next.queue.push = 1'b0;
    st_next.queue.chan = st_reg.queue.chan;
    st_next.queue.abcd = st_reg.queue.abcd;
    if (debounce && chan_queued)
    begin
      for (int b = 0; b < 4; b++)
      begin
        new_out[b] = (i_sig.abcd[b] == cur_in[b]) ? i_sig.abcd[b] : cur_out[b];
      end
    end
    if (i_sig.valid)
    begin
      // Input buffer keeps tracking the line even while frozen
      st_next.in_buf[i_sig.chan] = i_sig.abcd;
      if (!freeze_eff && (new_out != cur_out))
      begin
        st_next.out_buf[i_sig.chan] = new_out;
        if (chan_queued)
        begin
          st_next.queue.push = 1'b1;
          st_next.queue.chan = i_sig.chan;
          st_next.queue.abcd = new_out;
        end
      end
    end
    // Multiframe copy ends any debounce disagreement left over
    if (i_mf_end && debounce && !freeze_eff)
    begin
      for (int c = 0; c < 32; c++)
      begin
        if (st_reg.queue_en[c])
        begin
          st_next.out_buf[c] = st_next.in_buf[c];
        end
      end
    end

    // Receive multiframe sync placement
    if (st_reg.sig_cfg[`RSUS_CFG_TRANSPARENT])
    begin
      // Follows realignment silently; no alarm path exists here
      sync_frame = wrap_frame(i_rx_mf_align_frame, i_rx_slip_delay_frame,
                              st_reg.std_t1);
    end
    else
    begin
      sync_frame = ofs_frame(st_reg.frm_ofs, st_reg.std_t1);
    end
    sync_hit            = i_rx_frame_start && (i_rx_frame_num == sync_frame);
    st_next.mf_sync     = sync_hit;
    pos_now             = sync_hit ? 5'd1 : 5'(st_reg.mf_pos + 5'd1);
    st_next.reins_frame = 1'b0;
    if (i_rx_frame_start)
    begin
      st_next.mf_pos = pos_now;
      if (st_reg.std_t1)
      begin
        st_next.reins_frame = (pos_now == `RSUS_T1_SIG_F1) ||
                              (pos_now == `RSUS_T1_SIG_F2) ||
                              (pos_now == `RSUS_T1_SIG_F3) ||
                              (pos_now == `RSUS_T1_SIG_F4);
      end
      else
      begin
        st_next.reins_frame = (pos_now == 5'd1);
      end
    end

    // Slip events pend until their own frame boundary
    tx_ev  = slip_mask(st_reg.tx_mode, i_tx_slip.controlled | st_reg.tx_pend[1],
                       i_tx_slip.uncontrolled | st_reg.tx_pend[0]);
    rx_ev  = slip_mask(st_reg.rx_mode, i_rx_slip.controlled | st_reg.rx_pend[1],
                       i_rx_slip.uncontrolled | st_reg.rx_pend[0]);
    tx_dir = (i_tx_slip.controlled | i_tx_slip.uncontrolled) ? i_tx_slip.repeated
                                                              : st_reg.tx_pend[2];
    rx_dir = (i_rx_slip.controlled | i_rx_slip.uncontrolled) ? i_rx_slip.repeated
                                                              : st_reg.rx_pend[2];
    st_next.tx_pend = {tx_dir, tx_ev};
    st_next.rx_pend = {rx_dir, rx_ev};

    // Read clears, but a boundary in the same cycle still lands
    if (take && i_avs.read && (idx == `RSUS_IDX_SLIP_BUFFER_STATUS))
    begin
      tx_nib = 4'h0;
      rx_nib = 4'h0;
    end
    else
    begin
      tx_nib = st_reg.slip_buffer_status[7:4];
      rx_nib = st_reg.slip_buffer_status[3:0];
    end
    st_next.tx_int     = 1'b0;
    st_next.rx_int     = 1'b0;
    st_next.tx_realign = 1'b0;
    st_next.rx_realign = 1'b0;
    if (i_tx_frame_start)
    begin
      if (|tx_ev)
      begin
        tx_nib[`RSUS_ST_DIR] = tx_dir;
      end
      tx_nib[`RSUS_ST_CTL] = tx_nib[`RSUS_ST_CTL] | tx_ev[1];
      tx_nib[`RSUS_ST_UNC] = tx_nib[`RSUS_ST_UNC] | tx_ev[0];
      tx_nib[`RSUS_ST_DLY] = over_frame(i_tx_slip.separation, st_reg.std_t1);
      st_next.tx_int       = |tx_ev;
      st_next.tx_realign   = tx_ev[0];
      st_next.tx_pend      = 3'b000;
    end
    if (i_rx_frame_start)
    begin
      if (|rx_ev)
      begin
        rx_nib[`RSUS_ST_DIR] = rx_dir;
      end
      rx_nib[`RSUS_ST_CTL] = rx_nib[`RSUS_ST_CTL] | rx_ev[1];
      rx_nib[`RSUS_ST_UNC] = rx_nib[`RSUS_ST_UNC] | rx_ev[0];
      rx_nib[`RSUS_ST_DLY] = over_frame(i_rx_slip.separation, st_reg.std_t1);
      st_next.rx_int       = |rx_ev;
      st_next.rx_realign   = rx_ev[0];
      st_next.rx_pend      = 3'b000;
    end
    st_next.slip_buffer_status = {tx_nib, rx_nib};

    if (i_srst)
    begin
      st_next          = '0;
      st_next.bus      = RSUS_BUS_IDLE;
      st_next.sig_cfg  = `RSUS_RST_SIG_CFG;
      st_next.frm_ofs  = `RSUS_RST_FRM_OFS;
      st_next.slip_buffer_status    = `RSUS_RST_SLIP_BUFFER_STATUS;
      st_next.queue_en = `RSUS_RST_MASK32;
      st_next.reins_en = `RSUS_RST_MASK32;
      st_next.tx_mode  = RSUS_BUF_NORMAL;
      st_next.rx_mode  = RSUS_BUF_NORMAL;
    end
  end

  always_ff @(posedge i_clk)
  begin
    st_reg <= st_next;
  end

  // Waitrequest stays high until the answer cycle
  assign o_avs_waitrequest      = (st_reg.bus != RSUS_BUS_ACK);
  assign o_avs_readdata         = st_reg.rdata;
  assign o_signaling_freeze_pin = st_reg.freeze_pin;
  assign o_queue                = st_reg.queue;
  assign o_rx_multiframe_sync   = st_reg.mf_sync;
  assign o_reinsert_frame       = st_reg.reins_frame;
  assign o_reinsert_enable      = st_reg.reins_en;
  assign o_tx_slip_int          = st_reg.tx_int;
  assign o_rx_slip_int          = st_reg.rx_int;
  assign o_tx_frame_realign     = st_reg.tx_realign;
  assign o_rx_frame_realign     = st_reg.rx_realign;

endmodule // rsus_top

`default_nettype wire

// *** testbench/rsus_timebase_model.sv ***
// Framer timebase model: frame boundaries and receive bus frame numbering
`timescale 1ns/1ps
`default_nettype none

module rsus_timebase_model #(
  parameter int FRAME_CYC = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_t1,
  output logic            o_rx_frame_start,
  output logic            o_tx_frame_start,
  output logic [4:0]      o_rx_frame_num
);
  int cnt;

  // Short frames keep a whole multiframe within a few hundred cycles
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cnt            <= 0;
      o_rx_frame_num <= 5'h00;
    end
    else
    begin
      cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
      if (cnt == FRAME_CYC - 1)
        o_rx_frame_num <= i_t1 ? ((o_rx_frame_num >= 5'h18) ? 5'h01 : o_rx_frame_num + 5'h01)
                               : ((o_rx_frame_num >= 5'h0F) ? 5'h00 : o_rx_frame_num + 5'h01);
    end
  end

  // Transmit boundary deliberately out of phase with receive
  assign o_rx_frame_start = (cnt == 0);
  assign o_tx_frame_start = (cnt == 3);
endmodule // rsus_timebase_model

`default_nettype wire

// *** testbench/rsus_top_properties.sv ***
// Concurrent checks on the ports of the signaling update and slip status block
`timescale 1ns/1ps
`default_nettype none

module rsus_top_properties (
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  input  wire rsus_pkg::rsus_avs_req_t i_avs,
  input  wire logic                  o_avs_waitrequest,
  input  wire rsus_pkg::rsus_sig_in_t  i_sig,
  input  wire rsus_pkg::rsus_queue_t   o_queue,
  input  wire logic                  o_signaling_freeze_pin,
  input  wire logic                  i_rx_frame_start,
  input  wire logic                  i_tx_frame_start,
  input  wire logic                  o_rx_multiframe_sync,
  input  wire logic                  o_reinsert_frame,
  input  wire logic                  o_tx_slip_int,
  input  wire logic                  o_rx_slip_int,
  input  wire logic                  o_tx_frame_realign,
  input  wire logic                  o_rx_frame_realign
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  AST_WAIT_ONE_CYCLE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_REQ_ANSWERED: assert property ((i_avs.read || i_avs.write) && o_avs_waitrequest
    |-> ##[1:2] !o_avs_waitrequest) else $error("bus request not answered");
  AST_PUSH_CAUSE: assert property (o_queue.push |-> $past(i_sig.valid)
    && o_queue.chan == $past(i_sig.chan)) else $error("queue push without input");
  AST_PUSH_NOT_FROZEN: assert property (o_queue.push |-> !o_signaling_freeze_pin)
    else $error("queue push while frozen");
  AST_TX_INT_BOUNDARY: assert property (o_tx_slip_int |-> $past(i_tx_frame_start))
    else $error("tx slip int off boundary");
  AST_RX_INT_BOUNDARY: assert property (o_rx_slip_int |-> $past(i_rx_frame_start))
    else $error("rx slip int off boundary");
  AST_TX_REALIGN_SLIP: assert property (o_tx_frame_realign |-> o_tx_slip_int)
    else $error("tx realign without slip");
  AST_RX_REALIGN_SLIP: assert property (o_rx_frame_realign |-> o_rx_slip_int)
    else $error("rx realign without slip");
  AST_SYNC_AT_FRAME: assert property (o_rx_multiframe_sync |-> $past(i_rx_frame_start))
    else $error("multiframe sync off frame start");
  AST_REINS_AT_FRAME: assert property (o_reinsert_frame |-> $past(i_rx_frame_start))
    else $error("reinsert frame off frame start");

  COV_PUSH: cover property (o_queue.push);
  COV_TX_SLIP: cover property (o_tx_slip_int && o_tx_frame_realign);
  COV_SYNC: cover property (o_rx_multiframe_sync);
endmodule // rsus_top_properties

bind rsus_top rsus_top_properties i_props (
  .i_clk(i_clk), .i_srst(i_srst), .i_avs(i_avs), .o_avs_waitrequest(o_avs_waitrequest),
  .i_sig(i_sig), .o_queue(o_queue), .o_signaling_freeze_pin(o_signaling_freeze_pin),
  .i_rx_frame_start(i_rx_frame_start), .i_tx_frame_start(i_tx_frame_start),
  .o_rx_multiframe_sync(o_rx_multiframe_sync), .o_reinsert_frame(o_reinsert_frame),
  .o_tx_slip_int(o_tx_slip_int), .o_rx_slip_int(o_rx_slip_int),
  .o_tx_frame_realign(o_tx_frame_realign), .o_rx_frame_realign(o_rx_frame_realign));

`default_nettype wire

// *** testbench/test_rsus_top.sv ***
// Self-checking bench for the signaling update and slip status block
`timescale 1ns/1ps
`default_nettype none
`include "rsus_defines.svh"

module test_rsus_top;
  import rsus_pkg::*;
  logic           clk = 1'b0;
  logic           srst = 1'b1;
  rsus_avs_req_t  avs = '0;
  rsus_sig_in_t   sig = '0;
  rsus_slip_evt_t tx_slip = '0;
  rsus_slip_evt_t rx_slip = '0;
  logic           mf_end = 1'b0;
  logic           frz = 1'b0;
  logic           t1 = 1'b0;
  logic           dly_frame = 1'b0;
  logic [4:0]     align = 5'h00;
  logic           waitreq, mfsync, reins, frz_pin, tx_int, rx_int, tx_re, rx_re, rx_fs, tx_fs;
  logic [31:0]    rdata, reins_en, q32;
  logic [4:0]     fnum;
  rsus_queue_t    queue;
  int             fails = 0;
  int             checks = 0;

  always #10 clk = ~clk;

  rsus_top i_dut (.i_clk(clk), .i_srst(srst), .i_avs(avs), .o_avs_waitrequest(waitreq),
    .o_avs_readdata(rdata), .i_sig(sig), .i_mf_end(mf_end), .i_freeze_cond(frz),
    .i_rx_frame_start(rx_fs), .i_rx_frame_num(fnum), .i_rx_mf_align_frame(align),
    .i_rx_slip_delay_frame(dly_frame), .i_tx_frame_start(tx_fs), .i_tx_slip(tx_slip),
    .i_rx_slip(rx_slip), .o_signaling_freeze_pin(frz_pin), .o_queue(queue),
    .o_rx_multiframe_sync(mfsync), .o_reinsert_frame(reins), .o_reinsert_enable(reins_en),
    .o_tx_slip_int(tx_int), .o_rx_slip_int(rx_int), .o_tx_frame_realign(tx_re),
    .o_rx_frame_realign(rx_re));

  rsus_timebase_model i_model (.i_clk(clk), .i_srst(srst), .i_t1(t1),
    .o_rx_frame_start(rx_fs), .o_tx_frame_start(tx_fs), .o_rx_frame_num(fnum));

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs <= '{read: !wr, write: wr, address: {idx, 2'b00}, writedata: d, byteenable: 4'hF};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, q32);
  endtask

  task automatic rd(input string name, input logic [8:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h00000000, q);
    chk(name, q, exp);
  endtask

  task automatic send(input logic [4:0] ch, input logic [3:0] v, input logic ep,
                      input logic [3:0] ev);
    @(posedge clk);
    sig <= '{valid: 1'b1, chan: ch, abcd: v};
    @(posedge clk);
    sig.valid <= 1'b0;
    #1;
    chk("push", {31'h0, queue.push}, {31'h0, ep});
    if (ep)
      chk("queue entry", {23'h0, queue.chan, queue.abcd}, {23'h0, ch, ev});
  endtask

  task automatic t_regs;
    rd("frame offset", `RSUS_IDX_FRM_OFS, 32'h00000000);
    rd("slip status", `RSUS_IDX_SLIP_BUFFER_STATUS, 32'h00000000);
    wr(`RSUS_IDX_FRM_OFS, 32'h0000001F);
    rd("frame offset", `RSUS_IDX_FRM_OFS, 32'h0000001F);
    wr(`RSUS_IDX_SLIP_BUFFER_STATUS, 32'h000000FF);
    rd("slip status", `RSUS_IDX_SLIP_BUFFER_STATUS, 32'h00000000);
    rd("unmapped", 9'h0FF, 32'h00000000);
    wr(`RSUS_IDX_REINS_EN, 32'hA5A50F0F);
    chk("reinsert mask", reins_en, 32'hA5A50F0F);
    $display("test registers done");
  endtask

  task automatic t_plain;
    wr(`RSUS_IDX_QUEUE_EN, 32'h00000008);
    send(5'd3, 4'h5, 1'b1, 4'h5);
    rd("out buffer", 9'h1A3, 32'h00000005);
    send(5'd3, 4'h5, 1'b0, 4'h0);
    send(5'd4, 4'h9, 1'b0, 4'h0);
    rd("out buffer", 9'h1A4, 32'h00000009);
    $display("test plain update done");
  endtask

  task automatic t_freeze;
    frz <= 1'b1;
    send(5'd3, 4'h6, 1'b0, 4'h0);
    chk("freeze pin", {31'h0, frz_pin}, 32'h00000001);
    rd("out buffer", 9'h1A3, 32'h00000005);
    frz <= 1'b0;
    wr(`RSUS_IDX_SIG_CFG, 32'h00000002);
    send(5'd3, 4'h6, 1'b0, 4'h0);
    chk("freeze pin", {31'h0, frz_pin}, 32'h00000001);
    frz <= 1'b1;
    wr(`RSUS_IDX_SIG_CFG, 32'h00000004);
    send(5'd3, 4'h6, 1'b1, 4'h6);
    chk("freeze pin", {31'h0, frz_pin}, 32'h00000000);
    frz <= 1'b0;
    $display("test freeze done");
  endtask

  task automatic t_debounce;
    wr(`RSUS_IDX_SIG_CFG, 32'h00000008);
    send(5'd3, 4'h9, 1'b0, 4'h0);
    rd("out buffer", 9'h1A3, 32'h00000006);
    send(5'd3, 4'h9, 1'b1, 4'h9);
    send(5'd3, 4'hA, 1'b0, 4'h0);
    send(5'd4, 4'h3, 1'b0, 4'h0);
    rd("out buffer", 9'h1A4, 32'h00000003);
    @(posedge clk);
    mf_end <= 1'b1;
    @(posedge clk);
    mf_end <= 1'b0;
    rd("out buffer", 9'h1A3, 32'h0000000A);
    wr(`RSUS_IDX_SIG_CFG, 32'h00000000);
    $display("test debounce done");
  endtask

  task automatic slip_case(input logic [1:0] m, input logic t1v, input logic tx, input logic c,
                           input logic u, input logic r, input logic [8:0] sep,
                           input logic [7:0] exp);
    rsus_slip_evt_t e;
    logic [3:0]     nib;
    int             n;
    wr(`RSUS_IDX_LINE_CFG, {27'h0, m, m, t1v});
    t1 <= t1v;
    e = '{controlled: c, uncontrolled: u, repeated: r, separation: sep};
    nib = tx ? exp[7:4] : exp[3:0];
    @(posedge clk);
    if (tx)
      tx_slip <= e;
    else
      rx_slip <= e;
    @(posedge clk);
    tx_slip.controlled <= 1'b0;
    tx_slip.uncontrolled <= 1'b0;
    rx_slip.controlled <= 1'b0;
    rx_slip.uncontrolled <= 1'b0;
    n = 0;
    while (!(tx ? tx_int : rx_int) && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    // Expected pulse that never came is a hang, not a pass
    if (|nib[2:1] && n >= 40)
    begin
      fails++;
      wrap_up();
    end
    chk("slip int", {31'h0, n < 40}, {31'h0, |nib[2:1]});
    chk("realign", {31'h0, tx ? tx_re : rx_re}, {31'h0, nib[1]});
    rd("slip status", `RSUS_IDX_SLIP_BUFFER_STATUS, {24'h0, exp});
    tx_slip <= '0;
    rx_slip <= '0;
    repeat (20) @(posedge clk);
    rd("slip status", `RSUS_IDX_SLIP_BUFFER_STATUS, 32'h00000000);
  endtask

  task automatic t_slip;
    slip_case(2'b00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 9'd0, 8'hC0);
    slip_case(2'b00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 9'd0, 8'h60);
    slip_case(2'b01, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 9'd0, 8'hA0);
    slip_case(2'b00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 9'd300, 8'h03);
    slip_case(2'b00, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 9'd200, 8'h0D);
    slip_case(2'b00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 9'd192, 8'h00);
    slip_case(2'b10, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 9'd0, 8'hA0);
    slip_case(2'b11, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 9'd0, 8'h00);
    $display("test slip status done");
  endtask

  task automatic wait_frame(input string name, input logic sel, input logic [4:0] ef);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(sel ? mfsync : reins) && n < 600);
    if (n >= 600)
    begin
      fails++;
      wrap_up();
    end
    chk(name, {27'h0, fnum}, {27'h0, ef});
  endtask

  task automatic sync_case(input logic t1v, input logic tr, input logic [4:0] ofs,
                           input logic [4:0] al, input logic dl, input logic [4:0] ef);
    t1 <= t1v;
    align <= al;
    dly_frame <= dl;
    // Transparent runs go with a bypassed receive buffer, as software must set it
    wr(`RSUS_IDX_LINE_CFG, {27'h0, (tr ? 2'b11 : 2'b00), 2'b00, t1v});
    wr(`RSUS_IDX_SIG_CFG, {31'h0, tr});
    wr(`RSUS_IDX_FRM_OFS, {27'h0, ofs});
    wait_frame("sync frame", 1'b1, ef);
  endtask

  task automatic t_sync;
    sync_case(1'b0, 1'b0, 5'h13, 5'd0, 1'b0, 5'd3);
    sync_case(1'b0, 1'b0, 5'h0F, 5'd0, 1'b0, 5'd15);
    sync_case(1'b1, 1'b0, 5'h17, 5'd0, 1'b0, 5'd24);
    sync_case(1'b1, 1'b0, 5'h00, 5'd0, 1'b0, 5'd1);
    wait_frame("reinsert frame", 1'b0, 5'd6);
    sync_case(1'b1, 1'b1, 5'h00, 5'd24, 1'b1, 5'd1);
    sync_case(1'b0, 1'b1, 5'h00, 5'd4, 1'b1, 5'd5);
    $display("test multiframe sync done");
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_plain();
    t_freeze();
    t_debounce();
    t_slip();
    t_sync();
    wrap_up();
  end
endmodule // test_rsus_top

`default_nettype wire
